// ==== design/vpg_pkg.sv ====
// Constants and types of the video port global control block
package vpg_pkg;
   // Register subaddresses
   localparam logic [7:0] ADDR_CLK_TASK  = 8'h80;
   localparam logic [7:0] ADDR_EXP_PORT  = 8'h83;
   localparam logic [7:0] ADDR_SIG_SEL   = 8'h84;
   localparam logic [7:0] ADDR_FIFO_CTL  = 8'h86;
   localparam logic [7:0] ADDR_SW_RESET  = 8'h88;
   localparam logic [7:0] ADDR_FLAG_FORM = 8'h90;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] READ_UNMAPPED  = 8'h00;
   // Field positions
   localparam int BE_CLK_SEL_LSB  = 0;
   localparam int QUAL_MODE_BIT   = 2;
   localparam int QUAL_EXTENT_BIT = 3;
   localparam int TASK_A_EN_BIT   = 4;
   localparam int TASK_B_EN_BIT   = 5;
   localparam int TIMING_SRC_BIT  = 6;
   localparam int EXP_OE_LSB      = 0;
   localparam int READY_FUNC_BIT  = 2;
   localparam int EXP_PHASE_LSB   = 4;
   localparam int HREF_SEL_LSB    = 0;
   localparam int VREF_SEL_LSB    = 2;
   localparam int GP1_SEL_LSB     = 4;
   localparam int GP1_SEL_HI_BIT  = 4;
   localparam int EMPTY_LVL_LSB   = 0;
   localparam int FULL_LVL_LSB    = 2;
   localparam int SW_RESET_BIT    = 5;
   localparam int FIELD_FORM_BIT  = 6;
   localparam int TASK_FORM_BIT   = 7;
   // Back-end clock select codes
   localparam logic [1:0] BE_CLK_LLC  = 2'h0;
   localparam logic [1:0] BE_CLK_EXPANSION_PORT_CLOCK = 2'h1;
   localparam logic [1:0] BE_CLK_HALF = 2'h2;
   localparam logic [1:0] BE_CLK_IMAGE_PORT_CLOCK = 2'h3;
   // Expansion port output enable codes
   localparam logic [1:0] EXP_OE_OFF    = 2'h0;
   localparam logic [1:0] EXP_OE_ON     = 2'h1;
   localparam logic [1:0] EXP_OE_PINLOW = 2'h2;
   localparam logic [1:0] EXP_OE_PINHI  = 2'h3;
   // Horizontal and vertical reference codes
   localparam logic [1:0] HREF_GATE      = 2'h0;
   localparam logic [1:0] HREF_EXT_GATE  = 2'h1;
   localparam logic [1:0] HREF_PULSE     = 2'h2;
   localparam logic [1:0] HREF_EXT_PULSE = 2'h3;
   localparam logic [1:0] VREF_GATE      = 2'h0;
   localparam logic [1:0] VREF_INPUT     = 2'h1;
   localparam logic [1:0] VREF_GATE_PUL  = 2'h2;
   localparam logic [1:0] VREF_IN_PULSE  = 2'h3;
   // General-purpose pin 1 codes
   localparam logic [2:0] GP1_FIELD   = 3'h0;
   localparam logic [2:0] GP1_TASK    = 3'h1;
   localparam logic [2:0] GP1_SLICED  = 3'h2;
   localparam logic [2:0] GP1_ZERO    = 3'h3;
   localparam logic [2:0] GP1_FILLED  = 3'h4;
   localparam logic [2:0] GP1_OVERFLW = 3'h5;
   localparam logic [2:0] GP1_AFULL   = 3'h6;
   localparam logic [2:0] GP1_AEMPTY  = 3'h7;
   // FIFO level thresholds in dwords
   localparam logic [5:0] EMPTY_LT16 = 6'h10;
   localparam logic [5:0] EMPTY_LT8  = 6'h08;
   localparam logic [5:0] EMPTY_LT4  = 6'h04;
   localparam logic [5:0] FULL_GE16  = 6'h10;
   localparam logic [5:0] FULL_GE24  = 6'h18;
   localparam logic [5:0] FULL_GE28  = 6'h1c;
   localparam logic [5:0] FULL_32    = 6'h20;
   // Sampled pin indices
   localparam int SYNC_LLC  = 0;
   localparam int SYNC_EXPANSION_PORT_CLOCK = 1;
   localparam int SYNC_IMAGE_PORT_CLOCK = 2;
   localparam int SYNC_TRI  = 3;
   localparam int SYNC_W    = 4;
   // Expansion clock delay
   localparam int CORE_CLK_PERIOD_PS = 8000;
   localparam int EXP_CLK_DELAY_PS   = 3000;
   localparam int EXP_DELAY_RAW      = EXP_CLK_DELAY_PS / CORE_CLK_PERIOD_PS;
   localparam int EXP_DELAY_CYCLES   = (EXP_DELAY_RAW < 1) ? 1 : EXP_DELAY_RAW;

   typedef struct packed {
      logic       data_valid;
      logic       in_region;
      logic       h_gate;
      logic       h_ref_in;
      logic       in_window;
      logic       v_gate;
      logic       v_ref_in;
      logic       field_id;
      logic       slicer_field;
      logic       slicer_v;
      logic       task_flag;
      logic       sliced_flag;
      logic       ready;
      logic       fifo_almost_filled;
      logic       fifo_overflow;
      logic [5:0] fifo_level;
   } vpg_scaler_t;

   typedef struct packed {
      logic image_port_clock_output;
      logic image_data_qualifier;
      logic horizontal_reference_pin;
      logic vertical_reference_pin;
      logic general_purpose_pin_1;
      logic exp_clk;
      logic exp_oe;
      logic exp_ready_pin;
   } vpg_pins_t;
endpackage

// ==== design/vpg_global_control.sv ====
// Global control of the image and expansion video ports
`timescale 1ns/100ps

// Notes on behaviour
// - Two-bit clock select: 00 line clock, 01 expansion clock, 10 half rate, 11 input
// - Qualifier mode 0 gives plain qualifier; 1 gives back-end clock gated by it
// - Extent 0 qualifies valid scaled data; 1 also every word outside region
// - Task A runs only while its enable bit is 1
// - Task B runs only while its enable bit is 1
// - Timing source 0 takes field and vertical from window; 1 from slicer
// - Software reset lives at bit 5 of subaddress 88H, not the global register
// - Expansion clock phase: default, inverted, delayed, inverted and delayed
// - Expansion output enable: off, on, pin low enables, pin high enables
// - Ready function 0 puts the task flag, 1 for task A, on the ready pin
// - Ready function 1 puts scaler ready on the pin; source sends only while high
// - Horizontal pin: gate, extended gate, gate edge pulse, extended edge pulse
// - Vertical pin: gate, input reference, gate pulse, input reference pulse
// - Pin 1 codes 0-3: field ID, task flag, sliced data flag, logic 0
// - Pin 1 codes 4-7: almost filled, overflow, almost full, almost empty
// - Field ID and task flag forms follow bits 6 and 7 of subaddress 90H on pin 1 only
// - Almost full and empty thresholds come from subaddress 86H
module vpg_global_control (
   input  wire logic                core_clk_i,
   input  wire logic                srst_i,
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire logic [7:0]          reg_wdata_i,
   output logic      [7:0]          reg_rdata_o,
   input  wire logic                line_locked_clock_i,
   input  wire logic                expansion_port_clock_i,
   input  wire logic                image_port_clock_i,
   input  wire logic                exp_three_state_pin_i,
   input  wire vpg_pkg::vpg_scaler_t scaler_i,
   output vpg_pkg::vpg_pins_t       pins_o,
   output logic                     backend_clk_en_o,
   output logic                     task_a_enable_o,
   output logic                     task_b_enable_o,
   output logic                     software_reset_bit_o
);

   typedef struct packed {
      logic [7:0]                            clk_task;
      logic [7:0]                            exp_port;
      logic [7:0]                            sig_sel;
      logic [7:0]                            fifo_ctl;
      logic [7:0]                            sw_reset;
      logic [7:0]                            flag_form;
      logic [7:0]                            rdata;
      logic [vpg_pkg::SYNC_W-1:0]            sync1;
      logic [vpg_pkg::SYNC_W-1:0]            sync2;
      logic [vpg_pkg::SYNC_W-1:0]            sync3;
      logic [vpg_pkg::SYNC_W-1:0]            stable;
      logic                                  half_clk;
      logic                                  be_en;
      logic                                  h_prev;
      logic                                  h_ext_prev;
      logic                                  v_prev;
      logic                                  v_ref_prev;
      logic [vpg_pkg::EXP_DELAY_CYCLES-1:0]  exp_dly;
      logic                                  task_a_en;
      logic                                  task_b_en;
      vpg_pkg::vpg_pins_t                    pins;
   } vpg_state_t;

   vpg_state_t s_reg;
   vpg_state_t s_next;

   always_comb begin
      logic [vpg_pkg::SYNC_W-1:0] agree;
      logic [vpg_pkg::SYNC_W-1:0] rise;
      logic [1:0]                 be_sel;
      logic [1:0]                 oe_sel;
      logic [1:0]                 phase;
      logic [1:0]                 href_sel;
      logic [1:0]                 vref_sel;
      logic [2:0]                 gp1_sel;
      logic [1:0]                 empty_lvl;
      logic [1:0]                 full_lvl;
      logic                       be_clk_lvl;
      logic                       qual;
      logic                       h_ext;
      logic                       v_src;
      logic                       field_src;
      logic                       almost_full;
      logic                       almost_empty;
      logic                       expansion_port_clock_out;
      agree = '0;
      rise = '0;
      be_sel = '0;
      oe_sel = '0;
      phase = '0;
      href_sel = '0;
      vref_sel = '0;
      gp1_sel = '0;
      empty_lvl = '0;
      full_lvl = '0;
      be_clk_lvl = '0;
      qual = '0;
      h_ext = '0;
      v_src = '0;
      field_src = '0;
      almost_full = '0;
      almost_empty = '0;
      expansion_port_clock_out = '0;
      s_next = s_reg;

      // Register writes and read-back
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            vpg_pkg::ADDR_CLK_TASK:  s_next.clk_task  = reg_wdata_i;
            vpg_pkg::ADDR_EXP_PORT:  s_next.exp_port  = reg_wdata_i;
            vpg_pkg::ADDR_SIG_SEL:   s_next.sig_sel   = reg_wdata_i;
            vpg_pkg::ADDR_FIFO_CTL:  s_next.fifo_ctl  = reg_wdata_i;
            vpg_pkg::ADDR_SW_RESET:  s_next.sw_reset  = reg_wdata_i;
            vpg_pkg::ADDR_FLAG_FORM: s_next.flag_form = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            vpg_pkg::ADDR_CLK_TASK:  s_next.rdata = s_reg.clk_task;
            vpg_pkg::ADDR_EXP_PORT:  s_next.rdata = s_reg.exp_port;
            vpg_pkg::ADDR_SIG_SEL:   s_next.rdata = s_reg.sig_sel;
            vpg_pkg::ADDR_FIFO_CTL:  s_next.rdata = s_reg.fifo_ctl;
            vpg_pkg::ADDR_SW_RESET:  s_next.rdata = s_reg.sw_reset;
            vpg_pkg::ADDR_FLAG_FORM: s_next.rdata = s_reg.flag_form;
            default:                 s_next.rdata = vpg_pkg::READ_UNMAPPED;
         endcase
      end

      // Pin synchronisers; a change counts once stages two and three agree
      s_next.sync1  = {exp_three_state_pin_i, image_port_clock_i,
                       expansion_port_clock_i, line_locked_clock_i};
      s_next.sync2  = s_reg.sync1;
      s_next.sync3  = s_reg.sync2;
      agree         = ~(s_reg.sync2 ^ s_reg.sync3);
      s_next.stable = (agree & s_reg.sync3) | (~agree & s_reg.stable);
      rise          = s_next.stable & ~s_reg.stable;

      // Half-rate clock toggles on each line clock rising edge
      if (rise[vpg_pkg::SYNC_LLC]) begin
         s_next.half_clk = ~s_reg.half_clk;
      end

      // Back-end clock selection
      be_sel = s_reg.clk_task[vpg_pkg::BE_CLK_SEL_LSB +: 2];
      unique case (be_sel)
         vpg_pkg::BE_CLK_LLC: begin
            s_next.be_en = rise[vpg_pkg::SYNC_LLC];
            be_clk_lvl   = s_reg.stable[vpg_pkg::SYNC_LLC];
            s_next.pins.image_port_clock_output = s_reg.stable[vpg_pkg::SYNC_LLC];
         end
         vpg_pkg::BE_CLK_EXPANSION_PORT_CLOCK: begin
            s_next.be_en = rise[vpg_pkg::SYNC_EXPANSION_PORT_CLOCK];
            be_clk_lvl   = s_reg.stable[vpg_pkg::SYNC_EXPANSION_PORT_CLOCK];
            s_next.pins.image_port_clock_output = s_reg.stable[vpg_pkg::SYNC_EXPANSION_PORT_CLOCK];
         end
         vpg_pkg::BE_CLK_HALF: begin
            s_next.be_en = rise[vpg_pkg::SYNC_LLC] & ~s_reg.half_clk;
            be_clk_lvl   = s_reg.half_clk;
            s_next.pins.image_port_clock_output = s_reg.stable[vpg_pkg::SYNC_LLC];
         end
         vpg_pkg::BE_CLK_IMAGE_PORT_CLOCK: begin
            s_next.be_en = rise[vpg_pkg::SYNC_IMAGE_PORT_CLOCK];
            be_clk_lvl   = s_reg.stable[vpg_pkg::SYNC_IMAGE_PORT_CLOCK];
            s_next.pins.image_port_clock_output = 1'b0;
         end
      endcase

      // Task enables
      s_next.task_a_en = s_reg.clk_task[vpg_pkg::TASK_A_EN_BIT];
      s_next.task_b_en = s_reg.clk_task[vpg_pkg::TASK_B_EN_BIT];

      // Timing source for field and vertical
      field_src = s_reg.clk_task[vpg_pkg::TIMING_SRC_BIT] ?
                  scaler_i.slicer_field : scaler_i.field_id;
      v_src     = s_reg.clk_task[vpg_pkg::TIMING_SRC_BIT] ?
                  scaler_i.slicer_v : scaler_i.v_gate;

      // Data qualifier
      if (s_reg.clk_task[vpg_pkg::QUAL_EXTENT_BIT]) begin
         qual = scaler_i.in_region ? scaler_i.data_valid : 1'b1;
      end else begin
         qual = scaler_i.data_valid & scaler_i.in_region;
      end

      // Horizontal and vertical reference
      h_ext    = scaler_i.in_window ? scaler_i.h_gate : scaler_i.h_ref_in;
      href_sel = s_reg.sig_sel[vpg_pkg::HREF_SEL_LSB +: 2];
      vref_sel = s_reg.sig_sel[vpg_pkg::VREF_SEL_LSB +: 2];

      // FIFO flags against programmed thresholds
      empty_lvl = s_reg.fifo_ctl[vpg_pkg::EMPTY_LVL_LSB +: 2];
      full_lvl  = s_reg.fifo_ctl[vpg_pkg::FULL_LVL_LSB +: 2];
      unique case (empty_lvl)
         2'h0:    almost_empty = scaler_i.fifo_level < vpg_pkg::EMPTY_LT16;
         2'h1:    almost_empty = scaler_i.fifo_level < vpg_pkg::EMPTY_LT8;
         2'h2:    almost_empty = scaler_i.fifo_level < vpg_pkg::EMPTY_LT4;
         default: almost_empty = scaler_i.fifo_level == '0;
      endcase
      unique case (full_lvl)
         2'h0:    almost_full = scaler_i.fifo_level >= vpg_pkg::FULL_GE16;
         2'h1:    almost_full = scaler_i.fifo_level >= vpg_pkg::FULL_GE24;
         2'h2:    almost_full = scaler_i.fifo_level >= vpg_pkg::FULL_GE28;
         default: almost_full = scaler_i.fifo_level >= vpg_pkg::FULL_32;
      endcase
      gp1_sel = {s_reg.fifo_ctl[vpg_pkg::GP1_SEL_HI_BIT],
                 s_reg.sig_sel[vpg_pkg::GP1_SEL_LSB +: 2]};

      // Pins that follow the back-end clock
      if (s_reg.be_en) begin
         s_next.h_prev     = scaler_i.h_gate;
         s_next.h_ext_prev = h_ext;
         s_next.v_prev     = v_src;
         s_next.v_ref_prev = scaler_i.v_ref_in;
         s_next.pins.image_data_qualifier = qual;
         unique case (href_sel)
            vpg_pkg::HREF_GATE:      s_next.pins.horizontal_reference_pin = scaler_i.h_gate;
            vpg_pkg::HREF_EXT_GATE:  s_next.pins.horizontal_reference_pin = h_ext;
            vpg_pkg::HREF_PULSE:
               s_next.pins.horizontal_reference_pin = scaler_i.h_gate & ~s_reg.h_prev;
            vpg_pkg::HREF_EXT_PULSE:
               s_next.pins.horizontal_reference_pin = h_ext & ~s_reg.h_ext_prev;
         endcase
         unique case (vref_sel)
            vpg_pkg::VREF_GATE:     s_next.pins.vertical_reference_pin = v_src;
            vpg_pkg::VREF_INPUT:    s_next.pins.vertical_reference_pin = scaler_i.v_ref_in;
            vpg_pkg::VREF_GATE_PUL: s_next.pins.vertical_reference_pin = v_src & ~s_reg.v_prev;
            vpg_pkg::VREF_IN_PULSE:
               s_next.pins.vertical_reference_pin = scaler_i.v_ref_in & ~s_reg.v_ref_prev;
         endcase
         unique case (gp1_sel)
            vpg_pkg::GP1_FIELD:
               s_next.pins.general_purpose_pin_1 =
                  field_src ^ s_reg.flag_form[vpg_pkg::FIELD_FORM_BIT];
            vpg_pkg::GP1_TASK:
               s_next.pins.general_purpose_pin_1 =
                  scaler_i.task_flag ^ s_reg.flag_form[vpg_pkg::TASK_FORM_BIT];
            vpg_pkg::GP1_SLICED:  s_next.pins.general_purpose_pin_1 = scaler_i.sliced_flag;
            vpg_pkg::GP1_ZERO:    s_next.pins.general_purpose_pin_1 = 1'b0;
            vpg_pkg::GP1_FILLED:
               s_next.pins.general_purpose_pin_1 = scaler_i.fifo_almost_filled;
            vpg_pkg::GP1_OVERFLW: s_next.pins.general_purpose_pin_1 = scaler_i.fifo_overflow;
            vpg_pkg::GP1_AFULL:   s_next.pins.general_purpose_pin_1 = almost_full;
            vpg_pkg::GP1_AEMPTY:  s_next.pins.general_purpose_pin_1 = almost_empty;
         endcase
         s_next.pins.exp_ready_pin = s_reg.exp_port[vpg_pkg::READY_FUNC_BIT] ?
                                     scaler_i.ready :
                                     scaler_i.task_flag;
      end

      // Qualifier pin as plain level or gated back-end clock
      if (s_reg.clk_task[vpg_pkg::QUAL_MODE_BIT]) begin
         s_next.pins.image_data_qualifier = s_reg.pins.image_data_qualifier & be_clk_lvl;
         if (s_reg.be_en) begin
            s_next.pins.image_data_qualifier = qual & be_clk_lvl;
         end
      end

      // Expansion clock phase
      expansion_port_clock_out       = s_reg.stable[vpg_pkg::SYNC_EXPANSION_PORT_CLOCK];
      s_next.exp_dly = vpg_pkg::EXP_DELAY_CYCLES'({s_reg.exp_dly, expansion_port_clock_out});
      phase          = s_reg.exp_port[vpg_pkg::EXP_PHASE_LSB +: 2];
      s_next.pins.exp_clk = (phase[1] ? s_reg.exp_dly[vpg_pkg::EXP_DELAY_CYCLES-1] : expansion_port_clock_out)
                            ^ phase[0];

      // Expansion output enable
      oe_sel = s_reg.exp_port[vpg_pkg::EXP_OE_LSB +: 2];
      unique case (oe_sel)
         vpg_pkg::EXP_OE_OFF:    s_next.pins.exp_oe = 1'b0;
         vpg_pkg::EXP_OE_ON:     s_next.pins.exp_oe = 1'b1;
         vpg_pkg::EXP_OE_PINLOW: s_next.pins.exp_oe = ~s_reg.stable[vpg_pkg::SYNC_TRI];
         vpg_pkg::EXP_OE_PINHI:  s_next.pins.exp_oe = s_reg.stable[vpg_pkg::SYNC_TRI];
      endcase

      // Software reset clears the back-end pin state
      if (s_reg.sw_reset[vpg_pkg::SW_RESET_BIT]) begin
         s_next.pins.image_data_qualifier     = 1'b0;
         s_next.pins.horizontal_reference_pin = 1'b0;
         s_next.pins.vertical_reference_pin   = 1'b0;
         s_next.pins.general_purpose_pin_1    = 1'b0;
         s_next.pins.exp_ready_pin            = 1'b0;
         s_next.task_a_en                     = 1'b0;
         s_next.task_b_en                     = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_reg          <= '0;
         s_reg.clk_task <= vpg_pkg::REG_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata_o          = s_reg.rdata;
   assign pins_o               = s_reg.pins;
   assign backend_clk_en_o     = s_reg.be_en;
   assign task_a_enable_o      = s_reg.task_a_en;
   assign task_b_enable_o      = s_reg.task_b_en;
   assign software_reset_bit_o = s_reg.sw_reset[vpg_pkg::SW_RESET_BIT];

endmodule

// ==== verification/vpg_global_control_props.sv ====
// Assertions on the video port global control ports
`timescale 1ns/100ps
module vpg_global_control_props (
   input wire logic               core_clk_i,
   input wire logic               srst_i,
   input wire logic [7:0]         reg_addr_i,
   input wire logic               reg_wr_i,
   input wire logic               reg_rd_i,
   input wire logic [7:0]         reg_wdata_i,
   input wire logic [7:0]         reg_rdata_o,
   input wire vpg_pkg::vpg_pins_t pins_o,
   input wire logic               backend_clk_en_o,
   input wire logic               task_a_enable_o,
   input wire logic               task_b_enable_o,
   input wire logic               software_reset_bit_o
);
   logic qual_gated;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         qual_gated <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == vpg_pkg::ADDR_CLK_TASK) begin
         qual_gated <= reg_wdata_i[vpg_pkg::QUAL_MODE_BIT]; // Gated qualifier moves freely
      end
   end
   default clocking dck @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   chk_task_a_follow: assert property (
      (reg_wr_i && reg_addr_i == 8'h80 && !software_reset_bit_o) ##1 !reg_wr_i
      |=> task_a_enable_o == $past(reg_wdata_i[4], 2)) else $error("task A enable wrong");
   chk_task_b_follow: assert property (
      (reg_wr_i && reg_addr_i == 8'h80 && !software_reset_bit_o) ##1 !reg_wr_i
      |=> task_b_enable_o == $past(reg_wdata_i[5], 2)) else $error("task B enable wrong");
   chk_sw_reset_bit: assert property (
      (reg_wr_i && reg_addr_i == 8'h88) ##1 !reg_wr_i
      |=> software_reset_bit_o == $past(reg_wdata_i[5], 2)) else $error("reset bit wrong");
   chk_sw_readback: assert property (
      (!reg_wr_i) [*3] ##0 (reg_rd_i && reg_addr_i == 8'h88)
      |=> reg_rdata_o[5] == software_reset_bit_o) else $error("reset bit readback wrong");
   chk_unmapped_read: assert property (
      reg_rd_i && reg_addr_i == 8'h81 |=> reg_rdata_o == 8'h00) else $error("unmapped read");
   chk_rdata_holds: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without read");
   chk_be_pulse_one: assert property (
      backend_clk_en_o |=> !backend_clk_en_o) else $error("back-end enable too long");
   chk_pins_stand: assert property (
      !backend_clk_en_o && !software_reset_bit_o && !reg_wr_i |=> $stable({
      pins_o.horizontal_reference_pin, pins_o.vertical_reference_pin,
      pins_o.general_purpose_pin_1, pins_o.exp_ready_pin})
      && (qual_gated || $stable(pins_o.image_data_qualifier)))
      else $error("pin moved without back-end clock");
   chk_reset_stops_tasks: assert property (
      software_reset_bit_o |=> !task_a_enable_o && !task_b_enable_o)
      else $error("task ran in software reset");
   cov_be_pulse: cover property (backend_clk_en_o);
   cov_exp_oe: cover property (pins_o.exp_oe);
   cov_both_tasks: cover property (task_a_enable_o && task_b_enable_o);
endmodule
bind vpg_global_control vpg_global_control_props chk_i (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pins_o(pins_o),
   .backend_clk_en_o(backend_clk_en_o), .task_a_enable_o(task_a_enable_o),
   .task_b_enable_o(task_b_enable_o), .software_reset_bit_o(software_reset_bit_o));

// ==== verification/vpg_far_end.sv ====
// Far-side model: link clocks, three-state pin and ready-paced source
`timescale 1ns/100ps
module vpg_far_end (
   input  wire logic [2:0] run_i,
   input  wire logic       tri_lvl_i,
   input  wire logic       exp_ready_pin_i,
   output logic      [2:0] link_clk_o,
   output logic            exp_three_state_pin_o,
   output logic            word_sent_o
);
   initial begin
      link_clk_o = 3'h0;
      forever begin
         #62.5;
         link_clk_o = link_clk_o ^ run_i; // Stopped clocks stand still
      end
   end
   assign exp_three_state_pin_o = tri_lvl_i;
   assign word_sent_o = exp_ready_pin_i; // Source sends only while ready is high
endmodule

// ==== verification/tb_vpg_global_control.sv ====
// Bench for the video port global control block
`timescale 1ns/100ps
module tb_vpg_global_control;
   localparam int Q = 6, H = 5, V = 4, G = 3, XC = 2, OE = 1, RDY = 0;
   logic                 clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, tri_lvl = 1'b0, pv;
   logic [7:0]           addr = 8'h00, wdata = 8'h00, rdata, gp1_exp = 8'h65;
   logic [2:0]           run = 3'h7, lclk;
   logic                 be_en, ten_a, ten_b, swb, tri_pin;
   vpg_pkg::vpg_scaler_t sc = '0;
   vpg_pkg::vpg_pins_t   pins;
   int                   err_total = 0, checks = 0, cyc = 0, nb, ni;
   // Select, running clocks, back-end pulses, clock output rises per 250 cycles
   logic [14:0]          rate_tab [7] = '{15'h0610, 15'h0800, 15'h2a10, 15'h2400,
                                          15'h4510, 15'h7200, 15'h6400};
   logic [7:0]           regs [6] = '{8'h80, 8'h83, 8'h84, 8'h86, 8'h88, 8'h90};
   vpg_global_control dut (.core_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .line_locked_clock_i(lclk[0]), .expansion_port_clock_i(lclk[1]),
      .image_port_clock_i(lclk[2]), .exp_three_state_pin_i(tri_pin), .scaler_i(sc),
      .pins_o(pins), .backend_clk_en_o(be_en), .task_a_enable_o(ten_a),
      .task_b_enable_o(ten_b), .software_reset_bit_o(swb));
   vpg_far_end far_end (.run_i(run), .tri_lvl_i(tri_lvl), .exp_ready_pin_i(pins.exp_ready_pin),
      .link_clk_o(lclk), .exp_three_state_pin_o(tri_pin), .word_sent_o());
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk("rdata", rdata, exp);
   endtask
   task automatic pw(input logic [7:0] a, input logic [7:0] d, input int idx, input logic e);
      int n;
      wreg(a, d);
      n = 0;
      repeat (3) begin
         while (be_en !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
         end
         @(negedge clk);
      end
      chk($sformatf("pin%0d", idx), {7'h0, pins[idx]}, {7'h0, e});
      chk("be_wait", {7'h0, n >= 300}, 8'h00);
   endtask
   task automatic tasks_chk(input logic [7:0] d, input logic [1:0] e);
      wreg(8'h80, d);
      repeat (2) @(negedge clk);
      chk("task_en", {6'h0, ten_b, ten_a}, {6'h0, e});
   endtask
   initial begin
      {sc.h_gate, sc.v_gate, sc.field_id, sc.sliced_flag, sc.fifo_overflow} = 5'h1f;
      sc.fifo_level = 6'h14;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      foreach (regs[i]) rreg(regs[i], 8'h00);
      foreach (regs[i]) wreg(regs[i], regs[i] ^ 8'h5e);
      foreach (regs[i]) rreg(regs[i], regs[i] ^ 8'h5e);
      wreg(8'h81, 8'hff);
      rreg(8'h81, 8'h00);
      foreach (regs[i]) wreg(regs[i], 8'h00);
      tasks_chk(8'h30, 2'h3);
      tasks_chk(8'h10, 2'h1);
      wreg(8'h88, 8'h20);
      tasks_chk(8'h10, 2'h0);
      rreg(8'h80, 8'h10);
      wreg(8'h88, 8'h00);
      tasks_chk(8'h20, 2'h2);
      $display("end registers and tasks");
      foreach (rate_tab[i]) begin
         run = rate_tab[i][12:10];
         wreg(8'h80, {6'h01, rate_tab[i][14:13]});
         repeat (40) @(negedge clk);
         nb = 0;
         ni = 0;
         pv = pins.image_port_clock_output;
         repeat (250) begin
            @(negedge clk);
            nb += be_en;
            ni += pins.image_port_clock_output & ~pv;
            pv = pins.image_port_clock_output;
         end
         chk("be_pulses", nb[7:0], {3'h0, rate_tab[i][9:5]});
         chk("clk_out_rises", ni[7:0], {3'h0, rate_tab[i][4:0]});
      end
      run = 3'h7;
      $display("end clock select");
      {sc.data_valid, sc.in_region} = 2'h3;
      pw(8'h80, 8'h00, Q, 1'b1);
      {sc.data_valid, sc.in_region} = 2'h0;
      pw(8'h80, 8'h00, Q, 1'b0);
      pw(8'h80, 8'h08, Q, 1'b1);
      pw(8'h80, 8'h0c, Q, 1'b1);
      repeat (10) @(negedge clk);
      chk("gated_idq", {7'h0, pins[Q]}, 8'h00);
      pw(8'h84, 8'h00, H, 1'b1);
      pw(8'h84, 8'h01, H, 1'b0);
      pw(8'h84, 8'h02, H, 1'b0);
      pw(8'h84, 8'h00, V, 1'b1);
      pw(8'h84, 8'h04, V, 1'b0);
      pw(8'h84, 8'h08, V, 1'b0);
      for (int c = 0; c < 8; c++) begin
         wreg(8'h86, {3'h0, c[2], 4'h0});
         pw(8'h84, {2'h0, c[1:0], 4'h0}, G, gp1_exp[c]);
      end
      wreg(8'h86, 8'h1c);
      pw(8'h84, 8'h20, G, 1'b0);
      wreg(8'h86, 8'h00);
      pw(8'h84, 8'h00, G, 1'b1);
      pw(8'h90, 8'h40, G, 1'b0);
      pw(8'h90, 8'h00, G, 1'b1);
      pw(8'h80, 8'h40, G, 1'b0);
      $display("end image port pins");
      pw(8'h83, 8'h00, OE, 1'b0);
      pw(8'h83, 8'h01, OE, 1'b1);
      pw(8'h83, 8'h02, OE, 1'b1);
      pw(8'h83, 8'h03, OE, 1'b0);
      tri_lvl = 1'b1;
      pw(8'h83, 8'h03, OE, 1'b1);
      pw(8'h83, 8'h02, OE, 1'b0);
      pw(8'h83, 8'h00, RDY, 1'b0);
      sc.task_flag = 1'b1;
      pw(8'h83, 8'h00, RDY, 1'b1);
      pw(8'h83, 8'h04, RDY, 1'b0);
      sc.ready = 1'b1;
      pw(8'h83, 8'h04, RDY, 1'b1);
      run = 3'h5;
      pw(8'h83, 8'h00, XC, lclk[1]);
      pw(8'h83, 8'h10, XC, ~lclk[1]);
      pw(8'h83, 8'h30, XC, ~lclk[1]);
      $display("end expansion port");
      conclude();
   end
endmodule
